// ---- core/frmb_device.sv ----
// device end: register mailbox of the weighing transmitter
`timescale 1ns/100ps
`default_nettype none
// Function
// - put selected register value, then echo number
// - master waits for echo before reading
// - store write value, flag write active
// - master ends write by zero select
// - codes 80..127 except 123 set one bit
// - codes 208..255 clear one bit
// - bit commands ignore write value
// - bits read via whole register
// - control byte bits trigger actions
// - busy, error, last error, then idle
// - master waits busy, tests error
// - long actions use busy scheme
// - register 8 selects gross weight
// - read value big endian bytes 0..3
// - invalid weight on overload test error
// - negative values in two's complement
// - master writes value, index, bit 123
// - hold value, index; apply, clear 123
// - write value signed 32 bits
// - control actions on rising edge only
module frmb_device #(
  parameter int unsigned ACTION_CYCLES = frmb_pkg::FRMB_ACTION_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  frmb_if.device bus,
  input wire logic signed [31:0] gross_weight,
  input wire logic overload,
  input wire logic test_active,
  input wire logic adu_error,
  input wire logic action_fail,
  input wire logic [7:0] action_error_code,
  output logic [31:0] param_value_out,
  output logic [31:0] param_index_out,
  output logic param_apply,
  output logic [7:0] action_pulse,
  output logic [47:0] device_bits
);
  import frmb_pkg::*;
  logic [31:0] parameter_value_r;
  logic [31:0] parameter_index_r;
  logic [47:0] bits_r;
  logic [7:0] last_error_r;
  logic [7:0] trig_prev_r;
  logic write_active_r;
  logic busy_r;
  logic failed_r;
  logic [15:0] busy_cnt_r;
  logic [31:0] read_value_r;
  logic [7:0] read_echo_r;
  logic [31:0] sel_val;
  logic wr_go;
  logic [7:0] wsel;
  logic [5:0] bit_idx;
  logic bit_long;
  logic [7:0] trig_rise;

  assign wsel = bus.write_select;
  assign wr_go = (wsel != 8'h00) && !write_active_r;
  assign trig_rise = bus.action_trigger_byte & ~trig_prev_r;
  // bit index relative to code 80, same for set and clear
  assign bit_idx = 6'((wsel & ~FRMB_BIT_CLR_OFS) - FRMB_BIT_SET_MIN);
  assign bit_long = wr_go && frmb_is_bit_set(wsel) && (wsel != FRMB_BIT_PARAM_SET);

  // register decode for reads; bits reached only through whole registers
  always_comb
  begin
    case (bus.read_select)
      FRMB_REG_GROSS: sel_val = 32'(gross_weight);
      FRMB_REG_PARAM_VALUE: sel_val = parameter_value_r;
      FRMB_REG_PARAM_INDEX: sel_val = parameter_index_r;
      FRMB_REG_LAST_ERROR: sel_val = {24'h000000, last_error_r};
      FRMB_REG_BITS_LO: sel_val = bits_r[31:0];
      FRMB_REG_BITS_HI: sel_val = {16'h0000, bits_r[47:32]};
      FRMB_REG_STATUS: sel_val = {29'h0000000, adu_error, test_active, overload};
      default: sel_val = 32'h00000000;
    endcase
  end

  // value first, echo one cycle later so echo match means value valid
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      read_value_r <= 32'h00000000;
      read_echo_r <= 8'h00;
    end
    else if (clk_en)
    begin
      read_value_r <= sel_val;
      if (read_value_r == sel_val)
        read_echo_r <= bus.read_select;
      else
        read_echo_r <= 8'h00;
    end
  end

  // write handshake: act once, hold flag until select returns to zero
  always_ff @(posedge clk)
  begin
    if (reset)
      write_active_r <= 1'b0;
    else if (clk_en)
    begin
      if (wsel == 8'h00)
        write_active_r <= 1'b0;
      else
        write_active_r <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      parameter_value_r <= 32'h00000000;
      parameter_index_r <= 32'h00000000;
    end
    else if (clk_en && wr_go)
    begin
      if (wsel == FRMB_REG_PARAM_VALUE)
        parameter_value_r <= bus.write_value;
      if (wsel == FRMB_REG_PARAM_INDEX)
        parameter_index_r <= bus.write_value;
    end
  end

  // single bits; write value is never looked at here
  always_ff @(posedge clk)
  begin
    if (reset)
      bits_r <= 48'h000000000000;
    else if (clk_en && wr_go)
    begin
      if (frmb_is_bit_set(wsel) && wsel != FRMB_BIT_PARAM_SET)
        bits_r[bit_idx] <= 1'b1;
      else if (frmb_is_bit_clr(wsel))
        bits_r[bit_idx] <= 1'b0;
    end
  end

  // parameter bit 123 applies and is cleared at once, never stored
  always_ff @(posedge clk)
  begin
    if (reset)
      param_apply <= 1'b0;
    else if (clk_en)
      param_apply <= wr_go && (wsel == FRMB_BIT_PARAM_SET);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trig_prev_r <= 8'h00;
      action_pulse <= 8'h00;
    end
    else if (clk_en)
    begin
      trig_prev_r <= bus.action_trigger_byte;
      action_pulse <= trig_rise;
    end
  end

  // long action: busy, run, optional error, drop busy
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      failed_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      last_error_r <= FRMB_ERR_NONE;
    end
    else if (clk_en)
    begin
      if (!busy_r && (trig_rise != 8'h00 || bit_long || (wr_go && wsel == FRMB_BIT_PARAM_SET)))
      begin
        busy_r <= 1'b1;
        failed_r <= 1'b0;
        busy_cnt_r <= 16'(ACTION_CYCLES);
      end
      else if (busy_r)
      begin
        if (action_fail)
        begin
          failed_r <= 1'b1;
          last_error_r <= action_error_code;
        end
        if (busy_cnt_r <= 16'h0001)
          busy_r <= 1'b0;
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
    end
  end

  always_comb
  begin
    bus.status = 8'h00;
    bus.status[FRMB_ST_WRITE_ACTIVE] = write_active_r;
    bus.status[FRMB_ST_BUSY] = busy_r;
    bus.status[FRMB_ST_FAILED] = failed_r;
    bus.status[FRMB_ST_OVERLOAD] = overload;
    bus.status[FRMB_ST_TEST] = test_active;
    bus.status[FRMB_ST_ADU_ERR] = adu_error;
  end

  assign bus.read_value = read_value_r;
  assign bus.read_echo = read_echo_r;
  assign param_value_out = parameter_value_r;
  assign param_index_out = parameter_index_r;
  assign device_bits = bits_r;
endmodule // frmb_device
`default_nettype wire

// ---- core/frmb_pkg.sv ----
// package: constants and types shared by the mailbox ends
package frmb_pkg;
  localparam int unsigned FRMB_REG_W = 8;
  localparam int unsigned FRMB_VAL_W = 32;
  // register numbers
  localparam logic [7:0] FRMB_REG_GROSS = 8'h08;
  localparam logic [7:0] FRMB_REG_LAST_ERROR = 8'h0A;
  localparam logic [7:0] FRMB_REG_STATUS = 8'h01;
  localparam logic [7:0] FRMB_REG_PARAM_VALUE = 8'h14;
  localparam logic [7:0] FRMB_REG_PARAM_INDEX = 8'h15;
  localparam logic [7:0] FRMB_REG_BITS_LO = 8'h05;
  localparam logic [7:0] FRMB_REG_BITS_HI = 8'h06;
  // single-bit codes
  localparam logic [7:0] FRMB_BIT_SET_MIN = 8'h50;
  localparam logic [7:0] FRMB_BIT_SET_MAX = 8'h7F;
  localparam logic [7:0] FRMB_BIT_CLR_MIN = 8'hD0;
  localparam logic [7:0] FRMB_BIT_CLR_OFS = 8'h80;
  localparam logic [7:0] FRMB_BIT_PARAM_SET = 8'h7B;
  // status bit positions in the status byte
  localparam int unsigned FRMB_ST_WRITE_ACTIVE = 0;
  localparam int unsigned FRMB_ST_BUSY = 1;
  localparam int unsigned FRMB_ST_FAILED = 2;
  localparam int unsigned FRMB_ST_OVERLOAD = 3;
  localparam int unsigned FRMB_ST_TEST = 4;
  localparam int unsigned FRMB_ST_ADU_ERR = 5;
  // long-action duration in cycles
  localparam int unsigned FRMB_ACTION_CYCLES = 16;
  localparam logic [7:0] FRMB_ERR_NONE = 8'h00;
  typedef enum logic [1:0] {FRMB_WR_IDLE, FRMB_WR_WAIT, FRMB_WR_DONE} frmb_wr_state_t;
  typedef enum logic [2:0] {FRMB_MS_IDLE, FRMB_MS_RD, FRMB_MS_WR, FRMB_MS_WR_END,
    FRMB_MS_BUSY} frmb_ms_state_t;
  // is the code a single-bit set
  function automatic logic frmb_is_bit_set(input logic [7:0] c);
    return (c >= FRMB_BIT_SET_MIN) && (c <= FRMB_BIT_SET_MAX);
  endfunction
  // is the code a single-bit clear
  function automatic logic frmb_is_bit_clr(input logic [7:0] c);
    return c >= FRMB_BIT_CLR_MIN;
  endfunction
endpackage

// ---- core/frmb_if.sv ----
// interface: cyclic input and output process-data areas
`timescale 1ns/100ps
`default_nettype none
interface frmb_if;
  // input area, master to device
  logic [31:0] write_value;
  logic [7:0] read_select;
  logic [7:0] write_select;
  logic [7:0] action_trigger_byte;
  // output area, device to master
  logic [31:0] read_value;
  logic [7:0] read_echo;
  logic [7:0] status;
  modport device (input write_value, read_select, write_select, action_trigger_byte,
    output read_value, read_echo, status);
  modport master (output write_value, read_select, write_select, action_trigger_byte,
    input read_value, read_echo, status);
endinterface
`default_nettype wire

// ---- core/frmb_master.sv ----
// master end: drives the input area from simple user commands
`timescale 1ns/100ps
`default_nettype none
module frmb_master (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  frmb_if.master bus,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [7:0] cmd_select,
  input wire logic signed [31:0] cmd_value,
  input wire logic [7:0] trigger_bits,
  input wire logic wait_busy,
  output logic cmd_ready,
  output logic done,
  output logic [31:0] rd_data,
  output logic rd_invalid,
  output logic cmd_failed
);
  import frmb_pkg::*;
  frmb_ms_state_t state_r;
  logic [7:0] sel_r;
  logic [31:0] wval_r;
  logic [7:0] rsel_r;
  logic [7:0] trig_r;
  logic busy_wait_r;

  assign cmd_ready = (state_r == FRMB_MS_IDLE);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= FRMB_MS_IDLE;
      sel_r <= 8'h00;
      wval_r <= 32'h00000000;
      rsel_r <= 8'h00;
      trig_r <= 8'h00;
      busy_wait_r <= 1'b0;
      done <= 1'b0;
      rd_data <= 32'h00000000;
      rd_invalid <= 1'b0;
      cmd_failed <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      trig_r <= trigger_bits;
      case (state_r)
        FRMB_MS_IDLE:
        begin
          busy_wait_r <= wait_busy;
          if (rd_req)
          begin
            rsel_r <= cmd_select;
            state_r <= FRMB_MS_RD;
          end
          else if (wr_req)
          begin
            wval_r <= cmd_value;
            sel_r <= cmd_select;
            state_r <= FRMB_MS_WR;
          end
        end
        FRMB_MS_RD:
          if (bus.read_echo == rsel_r)
          begin
            rd_data <= bus.read_value;
            rd_invalid <= bus.status[FRMB_ST_OVERLOAD] | bus.status[FRMB_ST_TEST]
              | bus.status[FRMB_ST_ADU_ERR];
            done <= 1'b1;
            state_r <= FRMB_MS_IDLE;
          end
        FRMB_MS_WR:
          if (bus.status[FRMB_ST_WRITE_ACTIVE])
          begin
            sel_r <= 8'h00;
            state_r <= FRMB_MS_WR_END;
          end
        FRMB_MS_WR_END:
          if (!bus.status[FRMB_ST_WRITE_ACTIVE])
          begin
            if (busy_wait_r)
              state_r <= FRMB_MS_BUSY;
            else
            begin
              done <= 1'b1;
              state_r <= FRMB_MS_IDLE;
            end
          end
        FRMB_MS_BUSY:
          if (!bus.status[FRMB_ST_BUSY])
          begin
            cmd_failed <= bus.status[FRMB_ST_FAILED];
            done <= 1'b1;
            state_r <= FRMB_MS_IDLE;
          end
        default: state_r <= FRMB_MS_IDLE;
      endcase
    end
  end

  assign bus.write_value = wval_r;
  assign bus.write_select = sel_r;
  assign bus.read_select = rsel_r;
  assign bus.action_trigger_byte = trig_r;
endmodule // frmb_master
`default_nettype wire

// ---- sim/frmb_monitor.sv ----
// checker: handshake relations on the process-data areas
`timescale 1ns/100ps
`default_nettype none
module frmb_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] write_value,
  input wire logic [7:0] read_select,
  input wire logic [7:0] write_select,
  input wire logic [7:0] action_trigger_byte,
  input wire logic [31:0] read_value,
  input wire logic [7:0] read_echo,
  input wire logic [7:0] status
);
  import frmb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  echo_settled_a: assert property (
    ($stable(read_select) && $stable(read_value)) [*3] |-> read_echo == read_select)
    else $error("echo differs from a settled select");
  echo_source_a: assert property (
    read_echo != 8'h00 |-> read_echo == read_select || read_echo == $past(read_select)
    || read_echo == $past(read_select, 2)) else $error("echo not taken from select");
  wr_ack_a: assert property (
    write_select != 8'h00 && !status[FRMB_ST_WRITE_ACTIVE] |=> status[FRMB_ST_WRITE_ACTIVE])
    else $error("write not acknowledged");
  wr_rise_a: assert property (
    $rose(status[FRMB_ST_WRITE_ACTIVE]) |-> $past(write_select) != 8'h00)
    else $error("write flag without select");
  wr_hold_a: assert property (
    status[FRMB_ST_WRITE_ACTIVE] && write_select != 8'h00 |=> status[FRMB_ST_WRITE_ACTIVE])
    else $error("write flag dropped early");
  wr_fall_a: assert property (
    $fell(status[FRMB_ST_WRITE_ACTIVE]) |-> $past(write_select) == 8'h00)
    else $error("write flag cleared with select set");
  wr_value_hold_a: assert property (
    write_select != 8'h00 |=> $stable(write_value))
    else $error("write value moved during a write");
  act_start_a: assert property (
    (action_trigger_byte & ~$past(action_trigger_byte)) != 8'h00 && !status[FRMB_ST_BUSY]
    |=> status[FRMB_ST_BUSY]) else $error("control bit rise did not start an action");
  busy_bound_a: assert property (
    $rose(status[FRMB_ST_BUSY]) |-> ##[1:40] !status[FRMB_ST_BUSY])
    else $error("busy never ends");
  fail_in_busy_a: assert property (
    $rose(status[FRMB_ST_FAILED]) |-> $past(status[FRMB_ST_BUSY]))
    else $error("failure flag outside an action");
  cover property (read_echo == FRMB_REG_GROSS && read_select == FRMB_REG_GROSS);
  cover property ($rose(status[FRMB_ST_WRITE_ACTIVE]));
  cover property ($fell(status[FRMB_ST_BUSY]) && status[FRMB_ST_FAILED]);
  cover property ($rose(status[FRMB_ST_BUSY]) && action_trigger_byte != 8'h00);
endmodule // frmb_monitor
`default_nettype wire

// ---- sim/test_fieldbus_register_mailbox.sv ----
// testbench: both mailbox ends joined, driven from the master user side
`timescale 1ns/100ps
`default_nettype none
module test_fieldbus_register_mailbox;
  import frmb_pkg::*;
  logic clk, reset, rd_req, wr_req, wait_busy, overload, test_active, adu_error, action_fail;
  logic cmd_ready, done, rd_invalid, cmd_failed, param_apply;
  logic [7:0] cmd_select, trigger_bits, action_error_code, action_pulse;
  logic signed [31:0] cmd_value, gross_weight;
  logic [31:0] param_value_out, param_index_out, rd_data;
  logic [47:0] device_bits, exp_bits;
  int bad_count = 0, n_compared = 0, apply_n = 0, act_n = 0;
  frmb_if bus_if ();
  frmb_device #(.ACTION_CYCLES(4)) frmb_device_inst (.clk(clk), .reset(reset), .clk_en(1'b1),
    .bus(bus_if), .gross_weight(gross_weight), .overload(overload), .test_active(test_active),
    .adu_error(adu_error), .action_fail(action_fail), .action_error_code(action_error_code),
    .param_value_out(param_value_out), .param_index_out(param_index_out),
    .param_apply(param_apply), .action_pulse(action_pulse), .device_bits(device_bits));
  frmb_master frmb_master_inst (.clk(clk), .reset(reset), .clk_en(1'b1), .bus(bus_if),
    .rd_req(rd_req), .wr_req(wr_req), .cmd_select(cmd_select), .cmd_value(cmd_value),
    .trigger_bits(trigger_bits), .wait_busy(wait_busy), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .rd_invalid(rd_invalid), .cmd_failed(cmd_failed));
  frmb_monitor frmb_monitor_inst (.clk(clk), .reset(reset), .write_value(bus_if.write_value),
    .read_select(bus_if.read_select), .write_select(bus_if.write_select),
    .action_trigger_byte(bus_if.action_trigger_byte), .read_value(bus_if.read_value),
    .read_echo(bus_if.read_echo), .status(bus_if.status));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // pulses seen on the device user side
  always @(posedge clk)
  begin
    apply_n <= apply_n + int'(param_apply);
    act_n <= act_n + $countones(action_pulse);
  end
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(inout int i);
    @(posedge clk);
    #1;
    i++;
    if (i > 80)
    begin
      check("wait bound", 1'b1, 1'b0);
      complete_run();
    end
  endtask
  task automatic wait_done();
    int i = 0;
    tick(i);
    while (done !== 1'b1)
      tick(i);
  endtask
  task automatic do_read(input logic [7:0] sel);
    @(posedge clk);
    cmd_select <= sel;
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    wait_done();
  endtask
  task automatic do_write(input logic [7:0] sel, input logic [31:0] val);
    @(posedge clk);
    cmd_select <= sel;
    cmd_value <= val;
    wr_req <= 1'b1;
    @(posedge clk);
    wr_req <= 1'b0;
    wait_done();
  endtask
  task automatic busy_cycle();
    int i = 0;
    while (bus_if.status[FRMB_ST_BUSY] !== 1'b1)
      tick(i);
    while (bus_if.status[FRMB_ST_BUSY] !== 1'b0)
      tick(i);
  endtask
  task automatic t_gross();
    gross_weight <= 32'hFFFFFB2E;
    do_read(FRMB_REG_GROSS);
    check("gross", rd_data, 48'hFFFFFB2E);
    check("value bytes", bus_if.read_value, 48'hFFFFFB2E);
    check("echo", bus_if.read_echo, 48'h8);
    check("ready", cmd_ready, 1'b1);
    check("valid", rd_invalid, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      {adu_error, test_active, overload} <= 3'b001 << k;
      do_read(FRMB_REG_GROSS);
      check("invalid", rd_invalid, 1'b1);
    end
    {adu_error, test_active, overload} <= 3'b000;
    do_read(8'h33);
    check("unmapped", rd_data, 48'h0);
    $display("gross read test done");
  endtask
  task automatic t_param();
    int n;
    do_read(FRMB_REG_PARAM_VALUE);
    check("value reset", rd_data, 48'h0);
    do_write(FRMB_REG_PARAM_VALUE, 32'h80000001);
    check("value", param_value_out, 48'h80000001);
    do_write(FRMB_REG_PARAM_INDEX, 32'h7);
    check("index", param_index_out, 48'h7);
    do_read(FRMB_REG_PARAM_VALUE);
    check("value back", rd_data, 48'h80000001);
    n = apply_n;
    do_write(FRMB_BIT_PARAM_SET, 32'h0);
    check("apply", apply_n, n + 1);
    check("no bit kept", device_bits, exp_bits);
    $display("parameter test done");
  endtask
  task automatic t_bits();
    logic [7:0] codes [4] = '{8'h50, 8'h6F, 8'h70, 8'h7F};
    foreach (codes[k])
    begin
      do_write(codes[k], 32'hFFFFFFFF);
      exp_bits[codes[k] - 8'h50] = 1'b1;
      check("bit set", device_bits, exp_bits);
    end
    check("no cmd failure", cmd_failed, 1'b0);
    do_read(FRMB_REG_BITS_LO);
    check("low bits", rd_data, {16'h0, exp_bits[31:0]});
    do_read(FRMB_REG_BITS_HI);
    check("high bits", rd_data, {32'h0, exp_bits[47:32]});
    foreach (codes[k])
    begin
      do_write(codes[k] + 8'h80, 32'h0);
      exp_bits[codes[k] - 8'h50] = 1'b0;
      check("bit clear", device_bits, exp_bits);
    end
    $display("bit test done");
  endtask
  task automatic t_action();
    int n = act_n;
    trigger_bits <= 8'h04;
    busy_cycle();
    repeat (6) @(posedge clk);
    check("one pulse", act_n, n + 1);
    check("no failure", bus_if.status[FRMB_ST_FAILED], 1'b0);
    action_fail <= 1'b1;
    trigger_bits <= 8'h02;
    busy_cycle();
    check("failure", bus_if.status[FRMB_ST_FAILED], 1'b1);
    do_write(FRMB_BIT_SET_MIN, 32'h0);
    check("cmd failed", cmd_failed, 1'b1);
    action_fail <= 1'b0;
    do_read(FRMB_REG_LAST_ERROR);
    check("last error", rd_data, 48'h5A);
    trigger_bits <= 8'h00;
    @(posedge clk);
    trigger_bits <= 8'h01;
    busy_cycle();
    check("failure cleared", bus_if.status[FRMB_ST_FAILED], 1'b0);
    trigger_bits <= 8'h00;
    $display("action test done");
  endtask
  initial
  begin
    {rd_req, wr_req, overload, test_active, adu_error, action_fail} = 6'h00;
    wait_busy = 1'b1;
    cmd_select = 8'h00;
    cmd_value = 32'h0;
    trigger_bits = 8'h00;
    action_error_code = 8'h5A;
    gross_weight = 32'h0;
    exp_bits = 48'h0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_gross();
    t_param();
    t_bits();
    t_action();
    complete_run();
  end
endmodule // test_fieldbus_register_mailbox
`default_nettype wire
